/* File: logic/pts_pkg.sv */
// package for the power table shaping block
package pts_pkg;

  localparam int unsigned TBL_DEPTH      = 8;
  localparam int unsigned IDX_W          = 3;
  localparam int unsigned SET_W          = 8;
  localparam logic [7:0]  PA_RESET_VALUE = 8'hc6;
  localparam logic [2:0]  IDX_ZERO       = 3'h0;
  localparam logic [2:0]  IDX_ONE        = 3'h1;
  // shaping counter steps per symbol
  localparam int unsigned STEPS_PER_SYM  = 8;
  localparam logic [2:0]  STEP_LAST      = 3'h7;

  typedef enum logic [1:0] {
    PTS_MOD_CONST,
    PTS_MOD_OOK,
    PTS_MOD_ASK
  } pts_mod_e;

  typedef enum {
    PTS_ST_IDLE,
    PTS_ST_RAMP_UP,
    PTS_ST_STEADY,
    PTS_ST_RAMP_DOWN
  } pts_state_e;

  // table write from the configuration port
  typedef struct packed {
    logic             wr;
    logic [2:0]       addr;
    logic [7:0]       data;
  } pts_wr_s;

  // transmit control from the modulator
  typedef struct packed {
    logic             tx_on;
    logic             sym_tick;
    logic             sym_bit;
    pts_mod_e         mode;
    logic [2:0]       index_limit;
  } pts_tx_s;

  typedef struct packed {
    logic [TBL_DEPTH-1:0][SET_W-1:0] entry;
  } pts_tbl_s;

endpackage

/* File: logic/pts_shaper.sv */
// transmit power selection: ramping, on-off keying and amplitude shaping
// Notes on behaviour
// - table holds eight amplifier settings
// - three-bit index limit picks steady entry in constant mode
// - ramps walk entries zero up to limit
// - limit zero disables ramping, uses entry zero
// - on-off keying: entry zero/one per symbol
// - sleep keeps only entry zero
// - shaping counter up on one, down zero
// - counter steps eight times per symbol
// - counter saturates at limit and zero
// - table resets to default setting
`timescale 1ns/1ps
module pts_shaper (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  // configuration port writes and power state
  input  wire pts_pkg::pts_wr_s  i_wr,
  input  wire logic              i_sleep_enter,
  // modulator side
  input  wire pts_pkg::pts_tx_s  i_tx,
  // amplifier side
  output logic [7:0]             o_pa_setting,
  output logic [2:0]             o_pa_index,
  output logic                   o_pa_active,
  output logic                   o_tx_done
);

  // =====================================================
  // state
  typedef struct packed {
    pts_pkg::pts_state_e fsm;
    logic [2:0]          cnt;
    logic [2:0]          sub;
    logic [7:0]          setting;
    logic [2:0]          index;
    logic                active;
    logic                done;
  } pts_state_s;

  pts_state_s        st_r;
  pts_state_s        st_nxt;
  pts_pkg::pts_tbl_s tbl;

  // =====================================================
  // table
  pts_table u_table (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_ce          (i_ce),
    .i_wr          (i_wr),
    .i_sleep_enter (i_sleep_enter),
    .o_tbl         (tbl)
  );

  function automatic logic [7:0] pick(input pts_pkg::pts_tbl_s t, input logic [2:0] idx);
    pick = t.entry[idx];
  endfunction

  // =====================================================
  // next state
  logic [2:0] lim;
  logic [2:0] sel;

  always_comb begin
    st_nxt = st_r;
    lim    = i_tx.index_limit;
    sel    = st_r.cnt;
    st_nxt.done = 1'b0;
    case (st_r.fsm)
      pts_pkg::PTS_ST_IDLE: begin
        st_nxt.cnt = pts_pkg::IDX_ZERO;
        st_nxt.sub = 3'h0;
        if (i_tx.tx_on) begin
          if (i_tx.mode == pts_pkg::PTS_MOD_CONST && lim != pts_pkg::IDX_ZERO) begin
            st_nxt.fsm = pts_pkg::PTS_ST_RAMP_UP;
          end else begin
            st_nxt.fsm = pts_pkg::PTS_ST_STEADY;
          end
        end
      end
      pts_pkg::PTS_ST_RAMP_UP: begin
        if (!i_tx.tx_on) begin
          st_nxt.fsm = pts_pkg::PTS_ST_RAMP_DOWN;
        end else if (st_r.cnt >= lim) begin
          st_nxt.fsm = pts_pkg::PTS_ST_STEADY;
        end else if (i_tx.sym_tick) begin
          st_nxt.cnt = st_r.cnt + 3'h1;
        end
      end
      pts_pkg::PTS_ST_STEADY: begin
        case (i_tx.mode)
          pts_pkg::PTS_MOD_OOK: begin
            sel = i_tx.sym_bit ? pts_pkg::IDX_ONE : pts_pkg::IDX_ZERO;
          end
          pts_pkg::PTS_MOD_ASK: begin
            // no sub-symbol rate input exists, so eight steps are spread over each symbol tick
            if (i_tx.sym_tick || st_r.sub != 3'h0) begin
              st_nxt.sub = (st_r.sub == pts_pkg::STEP_LAST) ? 3'h0 : st_r.sub + 3'h1;
              if (i_tx.sym_bit && st_r.cnt < lim) begin
                st_nxt.cnt = st_r.cnt + 3'h1;
              end else if (!i_tx.sym_bit && st_r.cnt != pts_pkg::IDX_ZERO) begin
                st_nxt.cnt = st_r.cnt - 3'h1;
              end
            end
            sel = st_r.cnt;
          end
          default: begin
            sel = lim;
            st_nxt.cnt = lim;
          end
        endcase
        if (!i_tx.tx_on) begin
          st_nxt.fsm = (i_tx.mode == pts_pkg::PTS_MOD_CONST && lim != pts_pkg::IDX_ZERO)
                       ? pts_pkg::PTS_ST_RAMP_DOWN : pts_pkg::PTS_ST_IDLE;
          st_nxt.done = (st_nxt.fsm == pts_pkg::PTS_ST_IDLE);
          st_nxt.cnt  = (i_tx.mode == pts_pkg::PTS_MOD_CONST) ? lim : pts_pkg::IDX_ZERO;
        end
      end
      pts_pkg::PTS_ST_RAMP_DOWN: begin
        if (st_r.cnt == pts_pkg::IDX_ZERO) begin
          st_nxt.fsm  = pts_pkg::PTS_ST_IDLE;
          st_nxt.done = 1'b1;
        end else if (i_tx.sym_tick) begin
          st_nxt.cnt = st_r.cnt - 3'h1;
        end
      end
      default: begin
        st_nxt.fsm = pts_pkg::PTS_ST_IDLE;
      end
    endcase
    st_nxt.active  = (st_r.fsm != pts_pkg::PTS_ST_IDLE);
    st_nxt.index   = sel;
    st_nxt.setting = pick(tbl, sel);
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '{fsm: pts_pkg::PTS_ST_IDLE, cnt: 3'h0, sub: 3'h0, setting: pts_pkg::PA_RESET_VALUE,
                index: 3'h0, active: 1'b0, done: 1'b0};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // =====================================================
  // outputs
  assign o_pa_setting = st_r.setting;
  assign o_pa_index   = st_r.index;
  assign o_pa_active  = st_r.active;
  assign o_tx_done    = st_r.done;

endmodule

/* File: logic/pts_table.sv */
// power level table storage, entry zero survives sleep
`timescale 1ns/1ps
module pts_table (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  // write and sleep
  input  wire pts_pkg::pts_wr_s  i_wr,
  input  wire logic              i_sleep_enter,
  // contents
  output pts_pkg::pts_tbl_s      o_tbl
);

  typedef struct packed {
    pts_pkg::pts_tbl_s tbl;
  } pts_tstate_s;

  pts_tstate_s st_r;
  pts_tstate_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < pts_pkg::TBL_DEPTH; i++) begin
      // sleep drops every entry but zero; a write to any other entry in the same cycle is also dropped
      if (i_sleep_enter && i != 0) begin
        st_nxt.tbl.entry[i] = pts_pkg::PA_RESET_VALUE;
      end else if (i_wr.wr && i_wr.addr == i[2:0]) begin
        st_nxt.tbl.entry[i] = i_wr.data;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= {pts_pkg::TBL_DEPTH{pts_pkg::PA_RESET_VALUE}};
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_tbl = st_r.tbl;

endmodule

/* File: sim/pts_chk.sv */
// port assertions for the power table shaper
`timescale 1ns/1ps
module pts_chk (
  input wire logic             i_mclk,
  input wire logic             i_resetn,
  input wire pts_pkg::pts_tx_s i_tx,
  input wire logic [7:0]       o_pa_setting,
  input wire logic [2:0]       o_pa_index,
  input wire logic             o_pa_active,
  input wire logic             o_tx_done
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire ook = i_tx.mode == pts_pkg::PTS_MOD_OOK;
  // ==========
  // properties
  a_reset_default: assert property ($rose(i_resetn) |-> o_pa_setting == 8'hc6 && o_pa_index == 3'h0)
    else $error("setting not at default after reset");
  a_limit_bound: assert property (o_pa_active && !ook && $stable(i_tx.index_limit) |-> o_pa_index <= i_tx.index_limit)
    else $error("index above limit");
  a_ook_pair: assert property (o_pa_active && ook && $past(ook) |-> o_pa_index[2:1] == 2'h0)
    else $error("keying index outside entries zero and one");
  a_limit_zero: assert property (o_pa_active && !ook && i_tx.index_limit == 3'h0 |-> o_pa_index == 3'h0)
    else $error("ramp with limit zero");
  a_step_one: assert property (o_pa_active && $past(o_pa_active) && !ook && !$past(ook)
    |-> o_pa_index == $past(o_pa_index) || o_pa_index == $past(o_pa_index) + 3'h1
        || o_pa_index == $past(o_pa_index) - 3'h1)
    else $error("index jumped");
  a_start_zero: assert property ($rose(o_pa_active) && !ook |-> o_pa_index == 3'h0)
    else $error("transmission not started at entry zero");
  a_done_pulse: assert property (o_tx_done |=> !o_tx_done)
    else $error("done longer than one cycle");
  a_done_after: assert property (o_tx_done |-> $past(o_pa_active))
    else $error("done without transmission");
endmodule
bind pts_shaper pts_chk u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_tx(i_tx), .o_pa_setting(o_pa_setting),
  .o_pa_index(o_pa_index), .o_pa_active(o_pa_active), .o_tx_done(o_tx_done));

/* File: sim/pts_host.sv */
// host model that writes the power level table
`timescale 1ns/1ps
module pts_host (
  input  wire logic        i_mclk,
  output pts_pkg::pts_wr_s o_wr
);
  initial o_wr = '0;
  // the amplifier band 0x61..0x6f is moved away rather than written
  function automatic logic [7:0] clean(input logic [7:0] v);
    return (v > 8'h60 && v < 8'h70) ? v ^ 8'h80 : v;
  endfunction
  task automatic burst(input pts_pkg::pts_tbl_s t);
    for (int i = 0; i < 8; i++) begin
      o_wr <= '{1'b1, 3'(i), t.entry[i]};
      @(posedge i_mclk);
    end
    o_wr <= '0;
  endtask
endmodule

/* File: sim/pts_shaper_tb.sv */
// self-checking testbench for the power table shaper
`timescale 1ns/1ps
module pts_shaper_tb;
  logic clk = 0, rstn = 0, sleep = 0, ce = 1, act, done;
  pts_pkg::pts_wr_s wr;
  pts_pkg::pts_tx_s tx = '0;
  pts_pkg::pts_tbl_s tb;
  logic [7:0] set;
  logic [2:0] idx;
  int seed = 11718, n_mismatch = 0, n_compared = 0, cyc = 0, ndone = 0, d0 = 0;
  logic [11:0] q[$];
  event smp;
  initial forever #4 clk = ~clk;
  pts_host host (.i_mclk(clk), .o_wr(wr));
  pts_shaper uut (.i_mclk(clk), .i_resetn(rstn), .i_ce(ce), .i_wr(wr), .i_sleep_enter(sleep),
    .i_tx(tx), .o_pa_setting(set), .o_pa_index(idx), .o_pa_active(act), .o_tx_done(done));
  // ==========
  // scoreboard
  always @(smp) begin
    #1;
    n_compared++;
    if ({act, idx, set} !== q.pop_front()) begin
      n_mismatch++;
      $display("unexpected at %0t: active %b index %0d setting %h", $time, act, idx, set);
    end
  end
  always @(posedge clk) begin
    ndone += done;
    if (++cyc == 3000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task step(input int n); repeat (n) @(posedge clk); endtask
  task chk(input logic [2:0] i, input logic a = 1'b1); q.push_back({a, i, tb.entry[i]}); -> smp; endtask
  task tick; tx.sym_tick <= 1; step(1); tx.sym_tick <= 0; step(3); endtask
  task ook(input logic b); tx.sym_bit <= b; step(3); chk({2'h0, b}); endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    tb.entry = {8{pts_pkg::PA_RESET_VALUE}};
    step(5);
    rstn <= 1;
    tx.mode <= pts_pkg::PTS_MOD_OOK;
    tx.tx_on <= 1;
    ook(0);
    ook(1);
    tx.tx_on <= 0;
    step(3);
    for (int i = 0; i < 8; i++) tb.entry[i] = host.clean(8'($random(seed)));
    host.burst(tb);
    step(3);
    tx.tx_on <= 1;
    ook(0);
    ook(1);
    ook(0);
    tx.tx_on <= 0;
    // mode must not change in the cycle the transmission ends, or a ramp down starts
    step(3);
    tx.mode <= pts_pkg::PTS_MOD_CONST;
    tx.index_limit <= 3'h3;
    step(6);
    d0 = ndone;
    tx.tx_on <= 1;
    step(3);
    chk(0);
    for (int i = 1; i < 4; i++) begin tick; chk(3'(i)); end
    tx.tx_on <= 0;
    step(3);
    chk(3);
    for (int i = 2; i >= 0; i--) begin tick; chk(3'(i), i != 0); end
    repeat (3) tick;
    n_compared++;
    if (ndone - d0 !== 1) begin n_mismatch++; $display("unexpected at %0t: no done pulse", $time); end
    tx.index_limit <= 3'h0;
    tx.tx_on <= 1;
    step(3);
    chk(0);
    tick;
    chk(0);
    tx.tx_on <= 0;
    step(6);
    tx.mode <= pts_pkg::PTS_MOD_ASK;
    tx.index_limit <= 3'h7;
    tx.sym_bit <= 1;
    tx.tx_on <= 1;
    step(3);
    chk(0);
    tick; step(8); chk(7);
    tick; step(8); chk(7);
    tx.sym_bit <= 0;
    tick; step(8); chk(0);
    tx.tx_on <= 0;
    step(6);
    sleep <= 1;
    step(1);
    sleep <= 0;
    for (int i = 1; i < 8; i++) tb.entry[i] = pts_pkg::PA_RESET_VALUE;
    tx.mode <= pts_pkg::PTS_MOD_OOK;
    tx.tx_on <= 1;
    ook(1);
    ook(0);
    // clock enable low must hold the selection although the symbol changes
    ce <= 0;
    tx.sym_bit <= 1;
    step(3);
    chk(0);
    ce <= 1;
    finish_test;
  end
endmodule
